// *** io_port_pkg.sv ***
// Register map, field layout and pin function codes of the six-pin I/O port
package io_port_pkg;

	// Register byte addresses (word aligned)
	localparam logic [3:0] ADDR_DIRECTION     = 4'h0;
	localparam logic [3:0] ADDR_OUTPUT_DATA   = 4'h4;
	localparam logic [3:0] ADDR_PIN_STATE     = 4'h8;
	localparam logic [3:0] ADDR_OPEN_DRAIN    = 4'hC;
	localparam logic [3:0] ADDR_PERIPH_ENABLE = 4'h0;

	// Port width and reset values
	localparam int         PORT_PINS          = 6;
	localparam logic [5:0] DIRECTION_RESET    = 6'h00;
	localparam logic [5:0] OUTPUT_DATA_RESET  = 6'h00;
	localparam logic [5:0] OPEN_DRAIN_RESET   = 6'h00;

	// Value shown on undefined read bits (write-only register, reserved bits)
	localparam logic [31:0] UNDEF_READ        = 32'h0000_0000;

	// Peripheral enable register layout (extra control word)
	localparam int PE_TWOWIRE0      = 0;
	localparam int PE_TWOWIRE1      = 1;
	localparam int PE_SER0_TX       = 2;
	localparam int PE_SER0_RX       = 3;
	localparam int PE_SER1_TX       = 4;
	localparam int PE_SER1_RX       = 5;
	localparam int PE_SER0_CLK_OUT  = 6;
	localparam int PE_SER0_CLK_IN   = 7;
	localparam int PE_SER1_CLK_OUT  = 8;
	localparam int PE_SER1_CLK_IN   = 9;
	localparam int PE_WIDTH         = 10;
	localparam logic [PE_WIDTH-1:0] PERIPH_ENABLE_RESET = 10'h000;

	// Per-pin function selection
	typedef enum logic [2:0]
	{
		FN_GPIO     = 3'b000,
		FN_PERIPH_O = 3'b001,
		FN_PERIPH_I = 3'b010,
		FN_TWOWIRE  = 3'b011
	} pin_fn_t;

endpackage

// *** io_pin_cell.sv ***
// One port pin: output driver selection with open-drain and peripheral override
`timescale 1ns/1ps
`default_nettype none

module io_pin_cell
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                srst,
	// Selection
	input  wire io_port_pkg::pin_fn_t fn,
	input  wire logic                gpio_dir,
	input  wire logic                gpio_data,
	input  wire logic                open_drain,
	input  wire logic                periph_out,
	input  wire logic                twowire_drive_low,
	// Pin
	output logic                     pin_o,
	output logic                     pin_oe
);

	logic drive_d;
	logic value_d;
	logic od_d;

	always_comb
	begin
		drive_d = 1'b0;
		value_d = 1'b0;
		od_d    = open_drain;
		unique case (fn)
			io_port_pkg::FN_GPIO:
			begin
				drive_d = gpio_dir;
				value_d = gpio_data;
			end
			io_port_pkg::FN_PERIPH_O:
			begin
				drive_d = 1'b1;
				value_d = periph_out;
			end
			io_port_pkg::FN_PERIPH_I:
			begin
				drive_d = 1'b0;
			end
			io_port_pkg::FN_TWOWIRE:
			begin
				// Bus lines are always open drain
				drive_d = 1'b1;
				value_d = ~twowire_drive_low;
				od_d    = 1'b1;
			end
			default:
			begin
				drive_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pin_o  <= 1'b0;
			pin_oe <= 1'b0;
		end
		else
		begin
			pin_o  <= od_d ? 1'b0 : value_d;
			pin_oe <= drive_d & ~(od_d & value_d);
		end
	end

endmodule
`default_nettype wire

// *** six_bit_io_port.sv ***
// Six-pin general purpose I/O port with Avalon-MM register access
//
// Contract
// - six pins on register bits 5..0
// - direction register write-only, read undefined
// - direction 1 output, 0 input, reset 0
// - bits 7,6 reserved, writes ignored
// - output data register read/write, reset 0
// - pin-state register read-only, writes ignored
// - output pins read back data register
// - input pins read sampled pin level
// - pins 3..0 open drain or complementary
// - pins 5,4 open drain or push-pull
// - pins shared with serial, two-wire, interrupts
// - enabled peripheral overrides direction bit
// - two-wire enable wins over everything
`timescale 1ns/1ps
`default_nettype none

module six_bit_io_port
#(
	parameter int PINS = io_port_pkg::PORT_PINS
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Peripheral control block (second bank, address bit selects)
	input  wire logic        pe_select,
	// Peripheral side signals
	input  wire logic        serial0_transmit,
	input  wire logic        serial1_transmit,
	input  wire logic        serial0_clock_out,
	input  wire logic        serial1_clock_out,
	input  wire logic        twowire0_clock_low,
	input  wire logic        twowire0_data_low,
	input  wire logic        twowire1_clock_low,
	input  wire logic        twowire1_data_low,
	output logic             serial0_receive,
	output logic             serial1_receive,
	output logic             serial0_clock_in,
	output logic             serial1_clock_in,
	output logic             twowire0_clock_in,
	output logic             twowire0_data_in,
	output logic             twowire1_clock_in,
	output logic             twowire1_data_in,
	output logic             ext_interrupt_four,
	output logic             ext_interrupt_five,
	// Pins
	input  wire logic [PINS-1:0] pin_i,
	output logic      [PINS-1:0] pin_o,
	output logic      [PINS-1:0] pin_oe
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [PINS-1:0]                 direction_q;
	logic [PINS-1:0]                 output_data_q;
	logic [PINS-1:0]                 open_drain_q;
	logic [io_port_pkg::PE_WIDTH-1:0] periph_enable_q;
	logic [PINS-1:0]                 pin_meta_q;
	logic [PINS-1:0]                 pin_sync_q;
	logic                            ack_q;
	logic [31:0]                     readdata_d;
	logic                            access;
	logic                            wr_take;
	logic                            rd_take;

	// Each access answers one cycle after the request appears
	assign access  = (avs_read | avs_write) & ~ack_q;
	assign wr_take = avs_write & ack_q;
	assign rd_take = avs_read & ack_q;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic bank);
		hit = (a == off) && (pe_select == bank);
	endfunction

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ack_q <= 1'b0;
		end
		else
		begin
			ack_q <= access;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			avs_waitrequest <= ~access;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// pin-state has no write
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			direction_q <= io_port_pkg::DIRECTION_RESET;
		end
		else if (wr_take && avs_byteenable[0] && hit(avs_address, io_port_pkg::ADDR_DIRECTION, 1'b0))
		begin
			direction_q <= avs_writedata[PINS-1:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			output_data_q <= io_port_pkg::OUTPUT_DATA_RESET;
		end
		else if (wr_take && avs_byteenable[0] && hit(avs_address, io_port_pkg::ADDR_OUTPUT_DATA, 1'b0))
		begin
			output_data_q <= avs_writedata[PINS-1:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			open_drain_q <= io_port_pkg::OPEN_DRAIN_RESET;
		end
		else if (wr_take && avs_byteenable[0] && hit(avs_address, io_port_pkg::ADDR_OPEN_DRAIN, 1'b0))
		begin
			open_drain_q <= avs_writedata[PINS-1:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			periph_enable_q <= io_port_pkg::PERIPH_ENABLE_RESET;
		end
		else if (wr_take && hit(avs_address, io_port_pkg::ADDR_PERIPH_ENABLE, 1'b1))
		begin
			if (avs_byteenable[0])
			begin
				periph_enable_q[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1])
			begin
				periph_enable_q[9:8] <= avs_writedata[9:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	// two-stage input sync
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end
		else
		begin
			pin_meta_q <= pin_i;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb
	begin
		readdata_d = io_port_pkg::UNDEF_READ;
		if (!pe_select)
		begin
			unique case (avs_address)
				io_port_pkg::ADDR_DIRECTION:
					readdata_d = io_port_pkg::UNDEF_READ;
				io_port_pkg::ADDR_OUTPUT_DATA:
					readdata_d[PINS-1:0] = output_data_q;
				io_port_pkg::ADDR_PIN_STATE:
					readdata_d[PINS-1:0] = (direction_q & output_data_q)
						| (~direction_q & pin_sync_q);
				io_port_pkg::ADDR_OPEN_DRAIN:
					readdata_d[PINS-1:0] = open_drain_q;
				default:
					readdata_d = io_port_pkg::UNDEF_READ;
			endcase
		end
		else if (avs_address == io_port_pkg::ADDR_PERIPH_ENABLE)
		begin
			readdata_d[io_port_pkg::PE_WIDTH-1:0] = periph_enable_q;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			avs_readdata <= '0;
		end
		else if (access && avs_read)
		begin
			avs_readdata <= readdata_d;
		end
	end

	// ------------------------------------------------------------
	// Pin function selection
	// ------------------------------------------------------------
	io_port_pkg::pin_fn_t fn [PINS];
	logic [PINS-1:0]      periph_out;
	logic [PINS-1:0]      tw_low;

	always_comb
	begin
		for (int i = 0; i < PINS; i++)
		begin
			fn[i] = io_port_pkg::FN_GPIO;
		end
		periph_out = '0;
		tw_low     = '0;
		if (periph_enable_q[io_port_pkg::PE_SER0_TX])
		begin
			fn[0]         = io_port_pkg::FN_PERIPH_O;
			periph_out[0] = serial0_transmit;
		end
		if (periph_enable_q[io_port_pkg::PE_SER0_RX])
			fn[1] = io_port_pkg::FN_PERIPH_I;
		if (periph_enable_q[io_port_pkg::PE_SER0_CLK_IN])
			fn[2] = io_port_pkg::FN_PERIPH_I;
		else if (periph_enable_q[io_port_pkg::PE_SER0_CLK_OUT])
		begin
			fn[2]         = io_port_pkg::FN_PERIPH_O;
			periph_out[2] = serial0_clock_out;
		end
		if (periph_enable_q[io_port_pkg::PE_SER1_TX])
		begin
			fn[3]         = io_port_pkg::FN_PERIPH_O;
			periph_out[3] = serial1_transmit;
		end
		if (periph_enable_q[io_port_pkg::PE_SER1_RX])
			fn[4] = io_port_pkg::FN_PERIPH_I;
		if (periph_enable_q[io_port_pkg::PE_SER1_CLK_IN])
			fn[5] = io_port_pkg::FN_PERIPH_I;
		else if (periph_enable_q[io_port_pkg::PE_SER1_CLK_OUT])
		begin
			fn[5]         = io_port_pkg::FN_PERIPH_O;
			periph_out[5] = serial1_clock_out;
		end
		if (periph_enable_q[io_port_pkg::PE_TWOWIRE0])
		begin
			fn[5]     = io_port_pkg::FN_TWOWIRE;
			fn[4]     = io_port_pkg::FN_TWOWIRE;
			tw_low[5] = twowire0_clock_low;
			tw_low[4] = twowire0_data_low;
		end
		if (periph_enable_q[io_port_pkg::PE_TWOWIRE1])
		begin
			fn[3]     = io_port_pkg::FN_TWOWIRE;
			fn[2]     = io_port_pkg::FN_TWOWIRE;
			tw_low[3] = twowire1_clock_low;
			tw_low[2] = twowire1_data_low;
		end
	end

	genvar g;
	generate
		for (g = 0; g < PINS; g++)
		begin : g_pin
			io_pin_cell u_cell
			(
				.clk_sys           (clk_sys),
				.srst              (srst),
				.fn                (fn[g]),
				.gpio_dir          (direction_q[g]),
				.gpio_data         (output_data_q[g]),
				.open_drain        (open_drain_q[g]),
				.periph_out        (periph_out[g]),
				.twowire_drive_low (tw_low[g]),
				.pin_o             (pin_o[g]),
				.pin_oe            (pin_oe[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Peripheral inputs
	// ------------------------------------------------------------
	// shared input functions
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			serial0_receive    <= 1'b1;
			serial1_receive    <= 1'b1;
			serial0_clock_in   <= 1'b0;
			serial1_clock_in   <= 1'b0;
			twowire0_clock_in  <= 1'b1;
			twowire0_data_in   <= 1'b1;
			twowire1_clock_in  <= 1'b1;
			twowire1_data_in   <= 1'b1;
			ext_interrupt_four <= 1'b1;
			ext_interrupt_five <= 1'b1;
		end
		else
		begin
			serial0_receive    <= pin_sync_q[1];
			serial1_receive    <= pin_sync_q[4];
			serial0_clock_in   <= pin_sync_q[2];
			serial1_clock_in   <= pin_sync_q[5];
			twowire0_clock_in  <= pin_sync_q[5];
			twowire0_data_in   <= pin_sync_q[4];
			twowire1_clock_in  <= pin_sync_q[3];
			twowire1_data_in   <= pin_sync_q[2];
			ext_interrupt_four <= pin_sync_q[2];
			ext_interrupt_five <= pin_sync_q[5];
		end
	end

endmodule
`default_nettype wire

// *** six_bit_io_port_properties.sv ***
// Concurrent checks on the ports of the six-pin I/O port
`timescale 1ns/1ps
`default_nettype none

module six_bit_io_port_properties
#(
	parameter int PINS = 6
)
(
	// Clock, reset and bus
	input wire logic            clk_sys,
	input wire logic            srst,
	input wire logic [3:0]      avs_address,
	input wire logic            avs_read,
	input wire logic            avs_write,
	input wire logic            pe_select,
	input wire logic [31:0]     avs_readdata,
	input wire logic            avs_waitrequest,
	// Pins
	input wire logic [PINS-1:0] pin_i,
	input wire logic [PINS-1:0] pin_o,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic            ext_interrupt_four
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	property p_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_one: assert property (p_one) else $error("answer held too long");
	property p_idle;
		!(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_rst;
		disable iff (1'b0) srst |=> pin_oe == '0 && pin_o == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("pins driven after reset");
	property p_resv;
		!avs_waitrequest && avs_read && !pe_select |-> avs_readdata[31:6] == '0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	property p_dir;
		!avs_waitrequest && avs_read && !pe_select
			&& avs_address == io_port_pkg::ADDR_DIRECTION
			|-> avs_readdata == io_port_pkg::UNDEF_READ;
	endproperty
	a_dir: assert property (p_dir) else $error("direction read not undefined");
	property p_sync;
		$stable(pin_i[2]) [*6] |-> ext_interrupt_four == pin_i[2];
	endproperty
	a_sync: assert property (p_sync) else $error("pin level not followed");
	property p_ro;
		avs_write && !avs_waitrequest && !pe_select
			&& avs_address == io_port_pkg::ADDR_PIN_STATE
			|=> $stable(pin_o) && $stable(pin_oe);
	endproperty
	a_ro: assert property (p_ro) else $error("pin-state write moved pins");
endmodule

`default_nettype wire

// *** board_pins.sv ***
// Board model: external drivers and pull-ups on the six port pins
`timescale 1ns/1ps
`default_nettype none

module board_pins
(
	// Device drive
	input wire logic [5:0] pin_o,
	input wire logic [5:0] pin_oe,
	// Board drive
	input wire logic [5:0] ext_val,
	input wire logic [5:0] ext_en,
	// Pin level
	output logic     [5:0] pin_i
);
	always_comb
	begin
		for (int b = 0; b < 6; b++)
			pin_i[b] = pin_oe[b] ? pin_o[b] : (ext_en[b] ? ext_val[b] : 1'b1);
	end
endmodule

`default_nettype wire

// *** six_bit_io_port_bench.sv ***
// Self-checking bench for the six-pin I/O port
`timescale 1ns/1ps
`default_nettype none

module six_bit_io_port_bench;
	logic        clk_sys = 0;
	logic        srst = 1;
	logic [3:0]  avs_address = 0;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic        pe_select = 0;
	logic [31:0] avs_writedata = 0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        tw0_data_in;
	logic        irq_four;
	logic [7:0]  per = 0;
	logic [5:0]  pin_i, pin_o, pin_oe;
	logic [5:0]  ext_val = 0;
	logic [5:0]  ext_en = 0;
	logic [5:0]  m_dir, m_dat, m_od, m_oe, m_lvl, m_pin;
	logic [31:0] w, rd_q;
	int          miscompares = 0;
	int          n_checks = 0;

	six_bit_io_port dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pe_select(pe_select),
		.serial0_transmit(per[0]), .twowire0_clock_low(per[1]),
		.twowire0_data_low(per[2]), .serial1_transmit(per[3]),
		.serial0_clock_out(per[4]), .serial1_clock_out(per[5]),
		.twowire1_clock_low(per[6]), .twowire1_data_low(per[7]),
		.serial0_receive(), .serial1_receive(), .serial0_clock_in(),
		.serial1_clock_in(), .twowire0_clock_in(), .twowire0_data_in(tw0_data_in),
		.twowire1_clock_in(), .twowire1_data_in(), .ext_interrupt_four(irq_four),
		.ext_interrupt_five(), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
	board_pins board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val),
		.ext_en(ext_en), .pin_i(pin_i));

	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic pe, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_read <= !wr;
		avs_write <= wr;
		pe_select <= pe;
		avs_address <= a;
		avs_writedata <= d;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
		begin
			miscompares++;
			conclude();
		end
		rd_q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		conclude();
	end

	initial
	begin
		void'($urandom(95420));
		repeat (3) @(posedge clk_sys);
		srst <= 0;
		bus(0, 0, io_port_pkg::ADDR_OUTPUT_DATA, 0);
		chk(rd_q, io_port_pkg::OUTPUT_DATA_RESET);
		bus(0, 0, io_port_pkg::ADDR_OPEN_DRAIN, 0);
		chk(rd_q, io_port_pkg::OPEN_DRAIN_RESET);
		bus(0, 0, 4'h2, 0);
		chk(rd_q, io_port_pkg::UNDEF_READ);
		chk(pin_oe, io_port_pkg::DIRECTION_RESET);
		for (int i = 0; i < 24; i++)
		begin
			w = $urandom;
			m_dir = w[5:0];
			bus(1, 0, io_port_pkg::ADDR_DIRECTION, w);
			w = $urandom;
			m_dat = w[5:0];
			bus(1, 0, io_port_pkg::ADDR_OUTPUT_DATA, w);
			w = $urandom;
			m_od = w[5:0];
			bus(1, 0, io_port_pkg::ADDR_OPEN_DRAIN, w);
			w = $urandom;
			ext_val <= w[5:0];
			ext_en <= w[13:8];
			m_lvl = (w[5:0] & w[13:8]) | ~w[13:8];
			bus(1, 0, io_port_pkg::ADDR_PIN_STATE, $urandom);
			repeat (6) @(posedge clk_sys);
			m_oe = m_dir & ~(m_od & m_dat);
			chk(pin_oe, m_oe);
			chk(pin_o & pin_oe, m_dat & m_oe);
			m_pin = (m_oe & m_dat) | (~m_oe & m_lvl);
			chk({tw0_data_in, irq_four}, {m_pin[4], m_pin[2]});
			bus(0, 0, io_port_pkg::ADDR_PIN_STATE, 0);
			chk(rd_q, (m_dir & m_dat) | (~m_dir & m_lvl));
			bus(0, 0, io_port_pkg::ADDR_OUTPUT_DATA, 0);
			chk(rd_q, m_dat);
			bus(0, 0, io_port_pkg::ADDR_DIRECTION, 0);
			chk(rd_q, io_port_pkg::UNDEF_READ);
		end
		bus(1, 0, io_port_pkg::ADDR_OPEN_DRAIN, 0);
		bus(1, 1, io_port_pkg::ADDR_PERIPH_ENABLE, 32'h0000_0005);
		for (int i = 0; i < 16; i++)
		begin
			w = $urandom;
			per <= w[7:0];
			repeat (4) @(posedge clk_sys);
			chk({pin_oe[5], pin_o[5] & pin_oe[5]}, {w[1], 1'b0});
			chk({pin_oe[4], pin_oe[0], pin_o[0]}, {w[2], 1'b1, w[0]});
		end
		bus(1, 1, io_port_pkg::ADDR_PERIPH_ENABLE, 32'h0000_017A);
		for (int i = 0; i < 16; i++)
		begin
			w = $urandom;
			per <= w[7:0];
			repeat (4) @(posedge clk_sys);
			chk(pin_oe[3:2], {w[6], w[7]});
			chk(pin_o[3:2] & pin_oe[3:2], 2'b00);
			chk({pin_oe[5], pin_o[5], pin_oe[4], pin_oe[1], pin_oe[0]}, {1'b1, w[5], 2'b00, m_dir[0]});
		end
		bus(1, 1, io_port_pkg::ADDR_PERIPH_ENABLE, 0);
		conclude();
	end
endmodule

bind six_bit_io_port six_bit_io_port_properties #(.PINS(PINS)) u_props (.clk_sys(clk_sys),
	.srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.pe_select(pe_select), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .ext_interrupt_four(ext_interrupt_four));

`default_nettype wire
